// File: pmrc_map.svh
// Constants for the power mode and reset controller
`ifndef PMRC_MAP_SVH
`define PMRC_MAP_SVH
`define PMRC_EXT_LINES      16
`define PMRC_WAKE_BITS      25
`define PMRC_WK_RTC_ALARM   16
`define PMRC_WK_LOW_SUPPLY  17
`define PMRC_WK_CMP0        18
`define PMRC_WK_CMP1        19
`define PMRC_WK_USB         20
`define PMRC_WK_TAMPER      21
`define PMRC_WK_SERIAL      22
`define PMRC_WK_CEC         23
`define PMRC_WK_IRQ         24
`define PMRC_RST_HOLD_NS    64
`define PMRC_CLK_NS         4
`define PMRC_RST_HOLD_CYC   ((`PMRC_RST_HOLD_NS + `PMRC_CLK_NS - 1) / `PMRC_CLK_NS)
`define PMRC_BOOT_FLASH     2'h0
`define PMRC_BOOT_SYSMEM    2'h1
`define PMRC_BOOT_SRAM      2'h2
`define PMRC_CLK_IRC        2'h0
`endif

// File: pmrc_pkg.sv
// Types for the power mode and reset controller
package pmrc_pkg;
	typedef enum logic [4:0]
	{
		PMRC_RUN     = 5'h01,
		PMRC_SLEEP   = 5'h02,
		PMRC_DEEP    = 5'h04,
		PMRC_STANDBY = 5'h08,
		PMRC_RESET   = 5'h10
	} pmrc_mode_e;
	typedef struct packed
	{
		logic core_clk_en;
		logic periph_clk_en;
		logic fast_rc_en;
		logic fast_xtal_en;
		logic pll_en;
		logic regulator_en;
		logic core_domain_on;
	} pmrc_power_s;
	typedef struct packed
	{
		logic power_rst_n;
		logic system_rst_n;
		logic backup_rst_n;
	} pmrc_resets_s;
endpackage

// File: pmrc_reset_hold.sv
// Stretches a reset request into a held reset of fixed minimum length
`timescale 1ns/1ps
`include "pmrc_map.svh"
module pmrc_reset_hold
	import pmrc_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	input  wire logic req_in,
	output logic      rst_n_out
);
	localparam int unsigned HOLD = `PMRC_RST_HOLD_CYC;
	logic [7:0] cnt_ff;
	// Request keeps reloading, so reset lasts as long as the cause plus HOLD
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			cnt_ff <= 8'(HOLD);
		else if (req_in)
			cnt_ff <= 8'(HOLD);
		else if (cnt_ff != 8'h00)
			cnt_ff <= cnt_ff - 8'h01;
	end
	assign rst_n_out = (cnt_ff == 8'h00) && !req_in;
endmodule

// File: pmrc_top.sv
// Power mode sequencer and reset control
`timescale 1ns/1ps
`include "pmrc_map.svh"
module pmrc_top
	import pmrc_pkg::*;
(
	input  wire logic                       clk_in,
	input  wire logic                       reset_n_in,
	input  wire logic                       sleep_req_in,
	input  wire logic                       deep_req_in,
	input  wire logic                       standby_req_in,
	input  wire logic                       irq_pending_in,
	input  wire logic [`PMRC_EXT_LINES-1:0] external_event_lines_in,
	input  wire logic                       rtc_alarm_in,
	input  wire logic                       comparator_outputs_in,
	input  wire logic                       comparator1_out_in,
	input  wire logic                       usb_wake_in,
	input  wire logic                       rtc_tamper_in,
	input  wire logic                       first_serial_port_wake_in,
	input  wire logic                       cec_wake_in,
	input  wire logic                       free_watchdog_rst_in,
	input  wire logic                       external_reset_pin_n_in,
	input  wire logic                       wake_pin_in,
	input  wire logic                       supply_ok_in,
	input  wire logic                       supply_above_lvd_in,
	input  wire logic                       backup_rst_req_in,
	input  wire logic                       soft_rst_req_in,
	input  wire logic [1:0]                 boot_pins_in,
	output pmrc_power_s                     power_out,
	output pmrc_resets_s                    resets_out,
	output logic                            debug_port_rst_n_out,
	output logic [1:0]                      clk_sel_out,
	output logic [1:0]                      boot_src_out,
	output logic                            low_supply_irq_out,
	output pmrc_mode_e                      mode_out
);
	pmrc_mode_e                  mode_ff;
	pmrc_mode_e                  nxt_mode;
	logic [1:0]                  clk_sel_ff;
	logic [1:0]                  boot_src_ff;
	logic                        wake_pin_ff;
	logic                        low_supply_ff;
	logic                        power_req;
	logic                        sys_req;
	logic                        sys_rst_n;
	logic                        power_rst_n;
	logic [`PMRC_WAKE_BITS-1:0]  deep_wake;
	logic                        standby_wake;

	function automatic logic [1:0] decode_boot(input logic [1:0] pins);
		case (pins)
			2'b01:   decode_boot = `PMRC_BOOT_SYSMEM;
			2'b11:   decode_boot = `PMRC_BOOT_SRAM;
			default: decode_boot = `PMRC_BOOT_FLASH;
		endcase
	endfunction

	always_comb
	begin
		deep_wake = '0;
		deep_wake[`PMRC_EXT_LINES-1:0] = external_event_lines_in;
		deep_wake[`PMRC_WK_RTC_ALARM]  = rtc_alarm_in;
		deep_wake[`PMRC_WK_LOW_SUPPLY] = low_supply_ff;
		deep_wake[`PMRC_WK_CMP0]       = comparator_outputs_in;
		deep_wake[`PMRC_WK_CMP1]       = comparator1_out_in;
		deep_wake[`PMRC_WK_USB]        = usb_wake_in;
		deep_wake[`PMRC_WK_TAMPER]     = rtc_tamper_in;
		deep_wake[`PMRC_WK_SERIAL]     = first_serial_port_wake_in;
		deep_wake[`PMRC_WK_CEC]        = cec_wake_in;
		deep_wake[`PMRC_WK_IRQ]        = irq_pending_in;
	end

	// Only these four, besides supply loss and soft reset, leave standby
	assign standby_wake = !external_reset_pin_n_in || rtc_alarm_in || free_watchdog_rst_in
		|| (wake_pin_in && !wake_pin_ff);

	// Supply supervisor overrides everything
	assign power_req = !supply_ok_in;
	// Standby wake restarts the core domain as a reset
	assign sys_req = power_req || !external_reset_pin_n_in || free_watchdog_rst_in || soft_rst_req_in
		|| (mode_ff == PMRC_STANDBY && standby_wake);

	pmrc_reset_hold u_power_hold
	(
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.req_in     (power_req),
		.rst_n_out  (power_rst_n)
	);
	pmrc_reset_hold u_sys_hold
	(
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.req_in     (sys_req),
		.rst_n_out  (sys_rst_n)
	);

	always_comb
	begin
		nxt_mode = mode_ff;
		case (mode_ff)
			PMRC_RESET:   if (sys_rst_n) nxt_mode = PMRC_RUN;
			PMRC_RUN:
			begin
				if (standby_req_in)
					nxt_mode = PMRC_STANDBY;
				else if (deep_req_in)
					nxt_mode = PMRC_DEEP;
				else if (sleep_req_in)
					nxt_mode = PMRC_SLEEP;
			end
			PMRC_SLEEP:   if (irq_pending_in || |external_event_lines_in) nxt_mode = PMRC_RUN;
			PMRC_DEEP:    if (|deep_wake) nxt_mode = PMRC_RUN;
			PMRC_STANDBY: nxt_mode = PMRC_STANDBY;
			default:      nxt_mode = PMRC_RESET;
		endcase
		if (!sys_rst_n)
			nxt_mode = PMRC_RESET;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			mode_ff <= PMRC_RESET;
		else
			mode_ff <= nxt_mode;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			wake_pin_ff <= 1'b0;
		else
			wake_pin_ff <= wake_pin_in;
	end

	// Deep-sleep exit and reset both land on the internal fast RC
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			clk_sel_ff <= `PMRC_CLK_IRC;
		else if (mode_ff == PMRC_DEEP || mode_ff == PMRC_RESET)
			clk_sel_ff <= `PMRC_CLK_IRC;
	end

	// Pins caught on the last reset cycle, so a standby wake resamples them
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			boot_src_ff <= `PMRC_BOOT_FLASH;
		else if (mode_ff == PMRC_RESET && nxt_mode == PMRC_RUN)
			boot_src_ff <= decode_boot(boot_pins_in);
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			low_supply_ff <= 1'b0;
		else
			low_supply_ff <= !supply_above_lvd_in;
	end

	always_comb
	begin
		power_out = '0;
		case (mode_ff)
			PMRC_RUN:     power_out = 7'h7F;
			PMRC_SLEEP:   power_out = 7'h3F;
			PMRC_DEEP:    power_out = 7'h03;
			PMRC_STANDBY: power_out = 7'h00;
			PMRC_RESET:   power_out = 7'h13;
			default:      power_out = '0;
		endcase
	end

	// Three classes each from its own cause debug port only on power reset
	assign resets_out.power_rst_n  = power_rst_n;
	assign resets_out.system_rst_n = sys_rst_n;
	assign resets_out.backup_rst_n = !backup_rst_req_in;
	assign debug_port_rst_n_out    = power_rst_n;
	assign clk_sel_out             = clk_sel_ff;
	assign boot_src_out            = boot_src_ff;
	assign low_supply_irq_out      = low_supply_ff;
	assign mode_out                = mode_ff;

	property p_sleep_core_off;
		@(posedge clk_in) disable iff (!reset_n_in)
		mode_ff == PMRC_SLEEP |-> !power_out.core_clk_en && power_out.periph_clk_en;
	endproperty
	a_sleep_core_off: assert property (p_sleep_core_off) else $error("sleep clock gating wrong");

	property p_deep_off;
		@(posedge clk_in) disable iff (!reset_n_in)
		mode_ff == PMRC_DEEP |-> !power_out.fast_rc_en && !power_out.pll_en && power_out.core_domain_on;
	endproperty
	a_deep_off: assert property (p_deep_off) else $error("deep-sleep left oscillator on");

	property p_deep_wake;
		@(posedge clk_in) disable iff (!reset_n_in)
		mode_ff == PMRC_DEEP && |deep_wake && sys_rst_n |=> mode_ff == PMRC_RUN;
	endproperty
	a_deep_wake: assert property (p_deep_wake) else $error("deep-sleep wake missed");

	property p_deep_clk;
		@(posedge clk_in) disable iff (!reset_n_in)
		mode_ff == PMRC_DEEP ##1 mode_ff == PMRC_RUN |-> clk_sel_out == `PMRC_CLK_IRC;
	endproperty
	a_deep_clk: assert property (p_deep_clk) else $error("clock not internal RC after deep-sleep");

	property p_standby_off;
		@(posedge clk_in) disable iff (!reset_n_in)
		mode_ff == PMRC_STANDBY |-> !power_out.regulator_en && !power_out.core_domain_on;
	endproperty
	a_standby_off: assert property (p_standby_off) else $error("standby power left on");

	sequence s_wake_edge;
		mode_ff == PMRC_STANDBY && wake_pin_in && !wake_pin_ff;
	endsequence
	property p_standby_wake;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_wake_edge |=> mode_ff == PMRC_RESET && !resets_out.system_rst_n;
	endproperty
	a_standby_wake: assert property (p_standby_wake) else $error("standby wake not a reset");

	property p_supply_hold;
		@(posedge clk_in) disable iff (!reset_n_in)
		!supply_ok_in |-> !resets_out.power_rst_n && !resets_out.system_rst_n;
	endproperty
	a_supply_hold: assert property (p_supply_hold) else $error("reset released on low supply");

	property p_sys_spares;
		@(posedge clk_in) disable iff (!reset_n_in)
		soft_rst_req_in && supply_ok_in && power_rst_n |=> debug_port_rst_n_out;
	endproperty
	a_sys_spares: assert property (p_sys_spares) else $error("system reset hit debug port");

	property p_lvd;
		@(posedge clk_in) disable iff (!reset_n_in)
		!supply_above_lvd_in |=> low_supply_irq_out;
	endproperty
	a_lvd: assert property (p_lvd) else $error("low supply interrupt missing");

	property p_boot;
		@(posedge clk_in) disable iff (!reset_n_in)
		mode_ff == PMRC_RESET && nxt_mode == PMRC_RUN |=> boot_src_out == decode_boot($past(boot_pins_in));
	endproperty
	a_boot: assert property (p_boot) else $error("boot source wrong");

	property p_backup_sep;
		@(posedge clk_in) disable iff (!reset_n_in)
		!backup_rst_req_in |-> resets_out.backup_rst_n;
	endproperty
	a_backup_sep: assert property (p_backup_sep) else $error("backup reset without request");
endmodule

// File: pmrc_core_model.sv
// Partner model: processor core requests and wake-up sources
`timescale 1ns/1ps
module pmrc_core_model
	import pmrc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire pmrc_mode_e  mode_in,
	output logic [2:0]       req_out,
	output logic [27:0]      src_out
);
	logic [2:0]  req_ff;
	logic [27:0] src_ff;
	assign req_out = req_ff;
	assign src_out = src_ff;
	initial
	begin
		req_ff = 3'h0;
		src_ff = 28'h000_0000;
	end
	// Core stops asserting once it has entered low power, else it would fall straight back in
	always @(negedge clk_in)
		if (mode_in != PMRC_RUN)
			req_ff <= 3'h0;
	// Index 0 sleep, 1 deep-sleep, 2 standby; only issued while in run
	task automatic request(input int idx);
		@(negedge clk_in);
		req_ff[idx] <= 1'b1;
	endtask
	// Called at a falling edge; 26 is the reset pin, driven low when set
	task automatic wake(input int idx, input logic v);
		src_ff[idx] = v;
	endtask
endmodule

// File: pmrc_top_bench.sv
// Self-checking bench for the power mode and reset controller
`timescale 1ns/1ps
`include "pmrc_map.svh"
module pmrc_top_bench
	import pmrc_pkg::*;
;
	logic         clk_in = 0;
	logic         reset_n_in = 0;
	logic         sup_ok = 1;
	logic         lvd_ok = 1;
	logic         bk_req = 0;
	logic         sw_req = 0;
	logic [1:0]   boot = 2'h0;
	logic [2:0]   req;
	logic [27:0]  src;
	pmrc_power_s  pwr;
	pmrc_resets_s rst;
	pmrc_mode_e   mode;
	logic         dbg_n;
	logic [1:0]   csel;
	logic [1:0]   bsrc;
	logic         lirq;
	int           error_cnt = 0;
	int           samples_checked = 0;
	int           n;
	int           ws[4] = '{16, 25, 26, 27};
	always #2 clk_in = ~clk_in;
	pmrc_core_model core (.clk_in(clk_in), .mode_in(mode), .req_out(req), .src_out(src));
	pmrc_top uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .sleep_req_in(req[0]), .deep_req_in(req[1]),
		.standby_req_in(req[2]), .irq_pending_in(src[24]), .external_event_lines_in(src[15:0]),
		.rtc_alarm_in(src[16]), .comparator_outputs_in(src[18]), .comparator1_out_in(src[19]),
		.usb_wake_in(src[20]), .rtc_tamper_in(src[21]), .first_serial_port_wake_in(src[22]),
		.cec_wake_in(src[23]), .free_watchdog_rst_in(src[25]), .external_reset_pin_n_in(!src[26]),
		.wake_pin_in(src[27]), .supply_ok_in(sup_ok), .supply_above_lvd_in(lvd_ok),
		.backup_rst_req_in(bk_req), .soft_rst_req_in(sw_req), .boot_pins_in(boot), .power_out(pwr),
		.resets_out(rst), .debug_port_rst_n_out(dbg_n), .clk_sel_out(csel), .boot_src_out(bsrc),
		.low_supply_irq_out(lirq), .mode_out(mode));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wait_run();
		n = 0;
		while (mode !== PMRC_RUN && n < 300)
		begin
			@(negedge clk_in);
			n++;
		end
	endtask
	// Reset release must take the full hold before run resumes
	task automatic wait_hold();
		wait_run();
		chk("hold", (n >= `PMRC_RST_HOLD_CYC) && (n <= `PMRC_RST_HOLD_CYC + 2), 1);
	endtask
	task automatic t_boot();
		for (int i = 0; i < 4; i++)
		begin
			boot = 2'(i);
			reset_n_in = 0;
			@(negedge clk_in);
			chk("mode", mode, PMRC_RESET);
			chk("power", pwr, 7'h13);
			reset_n_in = 1;
			wait_hold();
			chk("boot", bsrc, i == 1 ? `PMRC_BOOT_SYSMEM : i == 3 ? `PMRC_BOOT_SRAM : `PMRC_BOOT_FLASH);
		end
		$display("test boot done");
	endtask
	task automatic t_sleep();
		for (int j = 0; j < 2; j++)
		begin
			core.request(0);
			@(negedge clk_in);
			chk("mode", mode, PMRC_SLEEP);
			chk("core_clk", pwr.core_clk_en, 0);
			chk("periph_clk", pwr.periph_clk_en, 1);
			core.wake(j ? 24 : 5, 1);
			@(negedge clk_in);
			chk("mode", mode, PMRC_RUN);
			core.wake(j ? 24 : 5, 0);
		end
		$display("test sleep done");
	endtask
	task automatic t_deep();
		for (int i = 0; i < 25; i++)
		begin
			core.request(1);
			@(negedge clk_in);
			chk("mode", mode, PMRC_DEEP);
			chk("power", pwr, 7'h03);
			if (i == 17)
				lvd_ok = 0;
			else
				core.wake(i, 1);
			wait_run();
			chk("deep_wake", n, i == 17 ? 2 : 1);
			chk("clk_sel", csel, `PMRC_CLK_IRC);
			if (i == 17)
				chk("low_irq", lirq, 1);
			lvd_ok = 1;
			core.wake(i, 0);
		end
		$display("test deep done");
	endtask
	task automatic t_standby();
		for (int k = 0; k < 4; k++)
		begin
			boot = 2'(k);
			core.request(2);
			@(negedge clk_in);
			chk("mode", mode, PMRC_STANDBY);
			chk("power", pwr, 7'h00);
			core.wake(24, 1);
			@(negedge clk_in);
			chk("mode", mode, PMRC_STANDBY);
			core.wake(24, 0);
			core.wake(ws[k], 1);
			#1 chk("sys_rst", rst.system_rst_n, 0);
			@(negedge clk_in);
			chk("mode", mode, PMRC_RESET);
			core.wake(ws[k], 0);
			wait_hold();
			chk("boot", bsrc, k == 1 ? `PMRC_BOOT_SYSMEM : k == 3 ? `PMRC_BOOT_SRAM : `PMRC_BOOT_FLASH);
		end
		$display("test standby done");
	endtask
	task automatic t_resets();
		sw_req = 1;
		#1 chk("resets", rst, 3'h5);
		chk("debug", dbg_n, 1);
		@(negedge clk_in);
		sw_req = 0;
		wait_hold();
		bk_req = 1;
		#1 chk("resets", rst, 3'h6);
		@(negedge clk_in);
		bk_req = 0;
		sup_ok = 0;
		repeat (40) @(negedge clk_in);
		chk("pwr_rst", rst.power_rst_n, 0);
		chk("debug", dbg_n, 0);
		chk("mode", mode, PMRC_RESET);
		sup_ok = 1;
		wait_hold();
		$display("test resets done");
	endtask
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Whole run needs a few hundred cycles; this leaves wide margin
	initial
	begin
		#80000;
		error_cnt++;
		end_of_test();
	end
	initial
	begin
		repeat (4) @(negedge clk_in);
		reset_n_in = 1;
		wait_hold();
		t_boot();
		t_sleep();
		t_deep();
		t_standby();
		t_resets();
		end_of_test();
	end
endmodule
